// *** pwtb_pkg.sv ***
// constants, field layout and register map of the pwm time base
package pwtb_pkg;
    localparam int CNT_W = 15;
    localparam int ADDR_W = 8;
    // byte offsets of the registers
    localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_PERIOD = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_COUNT = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_SEVT = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_MASK = 8'h14;
    // control register fields and the count register direction bit
    localparam int CTRL_ON_BIT = 15;
    localparam int CTRL_POST_LSB = 4;
    localparam int CTRL_PRE_LSB = 2;
    localparam int CTRL_MODE_LSB = 0;
    localparam int DIR_BIT = 15;
    // status and mask bits
    localparam int STAT_W = 2;
    localparam int STAT_TB_BIT = 0;
    localparam int STAT_SEV_BIT = 1;
    // reset values
    localparam logic [CNT_W-1:0] COUNT_RST = 15'h0000;
    localparam logic [CNT_W-1:0] PERIOD_RST = 15'h0000;
    localparam logic [CNT_W-1:0] SEVT_RST = 15'h0000;
    localparam logic [1:0] MODE_RST = 2'h0;
    localparam logic [1:0] PRE_RST = 2'h0;
    localparam logic [3:0] POST_RST = 4'h0;
    localparam logic [STAT_W-1:0] STAT_RST = 2'h0;
    // prescaler terminal counts
    localparam int PRE_W = 6;
    localparam logic [PRE_W-1:0] PRE_LIM_1 = 6'h00;
    localparam logic [PRE_W-1:0] PRE_LIM_4 = 6'h03;
    localparam logic [PRE_W-1:0] PRE_LIM_16 = 6'h0f;
    localparam logic [PRE_W-1:0] PRE_LIM_64 = 6'h3f;
    localparam int POST_W = 4;

    typedef enum logic [1:0] {
        PWTB_FREE = 2'h0,
        PWTB_SINGLE = 2'h1,
        PWTB_UPDOWN = 2'h2,
        PWTB_DOUBLE = 2'h3
    } pwtb_mode_t;

    typedef enum logic [1:0] {
        PWTB_UP = 2'b01,
        PWTB_DOWN = 2'b10
    } pwtb_dir_t;
endpackage : pwtb_pkg

// *** pwtb_scale_if.sv ***
// link between the time base and one of its divide-by-n scalers
`timescale 1ns/10ps
`default_nettype none
interface pwtb_scale_if #(parameter int W = 4);
    logic ev;
    logic clr;
    logic [W-1:0] limit;
    logic hit;
    modport ctl (output ev, output clr, output limit, input hit);
    modport scl (input ev, input clr, input limit, output hit);
endinterface : pwtb_scale_if
`default_nettype wire

// *** pwtb_scaler.sv ***
// divide-by-(limit+1) event counter used as prescaler and postscaler
`timescale 1ns/10ps
`default_nettype none
module pwtb_scaler #(
    parameter int W = 4
) (
    // clock and reset
    input wire logic clock_in,
    input wire logic resetn_in,
    // scaler link
    pwtb_scale_if.scl sc
);
    logic [W-1:0] count_q;

    // clear outranks a coincident event so no stale hit escapes
    assign sc.hit = sc.ev && !sc.clr && (count_q == sc.limit);

    always_ff @(posedge clock_in) begin
        if (!resetn_in) begin
            count_q <= '0;
        end else if (sc.clr) begin
            count_q <= '0;
        end else if (sc.ev) begin
            if (count_q >= sc.limit) begin
                count_q <= '0;
            end else begin
                count_q <= count_q + {{(W-1){1'b0}}, 1'b1};
            end
        end
    end
endmodule : pwtb_scaler
`default_nettype wire

// *** pwtb_time_base.sv ***
// pwm time base: counter, scalers, event logic and ahb-lite register slave
`timescale 1ns/10ps
`default_nettype none
module pwtb_time_base (
    // clock and reset
    input wire logic clock_in,
    input wire logic resetn_in,
    // ahb-lite slave
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out,
    // time base outputs
    output logic [14:0] count_value_out,
    output logic count_down_out,
    output logic special_event_out,
    output logic irq_out
);
    localparam int CW = pwtb_pkg::CNT_W;

    // bus state
    logic wr_pend_q;
    logic [pwtb_pkg::ADDR_W-1:0] wr_addr_q;
    logic [31:0] hrdata_q;
    logic [31:0] rd_mux;
    logic accept;
    logic wr_ctrl;
    logic wr_period;
    logic wr_count;
    logic wr_sevt;
    logic wr_status;
    logic wr_mask;

    // time base state
    logic [CW-1:0] count_q;
    logic [CW-1:0] period_q;
    logic [CW-1:0] sevt_q;
    pwtb_pkg::pwtb_dir_t dir_q;
    logic on_q;
    pwtb_pkg::pwtb_mode_t mode_q;
    logic [1:0] pre_sel_q;
    logic [3:0] post_sel_q;
    logic [pwtb_pkg::STAT_W-1:0] status_q;
    logic [pwtb_pkg::STAT_W-1:0] mask_q;
    logic [pwtb_pkg::STAT_W-1:0] stat_set;
    logic sev_q;
    logic irq_q;

    // event logic
    logic run;
    logic tick;
    logic match;
    logic at_zero;
    logic going_down;
    logic post_ev;
    logic direct_ev;
    logic tb_event;
    logic sev_hit;

    pwtb_scale_if #(.W(pwtb_pkg::PRE_W)) pre_if ();
    pwtb_scale_if #(.W(pwtb_pkg::POST_W)) post_if ();

    // ---------------- bus slave ----------------
    assign accept = hsel_in && htrans_in[1] && hready_in;
    assign wr_ctrl = wr_pend_q && (wr_addr_q == pwtb_pkg::OFS_CTRL);
    assign wr_period = wr_pend_q && (wr_addr_q == pwtb_pkg::OFS_PERIOD);
    assign wr_count = wr_pend_q && (wr_addr_q == pwtb_pkg::OFS_COUNT);
    assign wr_sevt = wr_pend_q && (wr_addr_q == pwtb_pkg::OFS_SEVT);
    assign wr_status = wr_pend_q && (wr_addr_q == pwtb_pkg::OFS_STATUS);
    assign wr_mask = wr_pend_q && (wr_addr_q == pwtb_pkg::OFS_MASK);

    always_ff @(posedge clock_in) begin
        if (!resetn_in) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= '0;
        end else begin
            wr_pend_q <= accept && hwrite_in;
            wr_addr_q <= haddr_in[pwtb_pkg::ADDR_W-1:0];
        end
    end

    always_comb begin
        rd_mux = 32'h0000_0000;
        case (haddr_in[pwtb_pkg::ADDR_W-1:0])
            pwtb_pkg::OFS_CTRL: begin
                rd_mux[pwtb_pkg::CTRL_ON_BIT] = on_q;
                rd_mux[pwtb_pkg::CTRL_POST_LSB +: 4] = post_sel_q;
                rd_mux[pwtb_pkg::CTRL_PRE_LSB +: 2] = pre_sel_q;
                rd_mux[pwtb_pkg::CTRL_MODE_LSB +: 2] = mode_q;
            end
            pwtb_pkg::OFS_PERIOD: rd_mux[CW-1:0] = period_q;
            pwtb_pkg::OFS_COUNT: begin
                rd_mux[CW-1:0] = count_q;
                rd_mux[pwtb_pkg::DIR_BIT] = (dir_q == pwtb_pkg::PWTB_DOWN);
            end
            pwtb_pkg::OFS_SEVT: rd_mux[CW-1:0] = sevt_q;
            pwtb_pkg::OFS_STATUS: rd_mux[pwtb_pkg::STAT_W-1:0] = status_q;
            pwtb_pkg::OFS_MASK: rd_mux[pwtb_pkg::STAT_W-1:0] = mask_q;
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // read data is captured at the address phase, so the slave never stalls
    always_ff @(posedge clock_in) begin
        if (!resetn_in) begin
            hrdata_q <= 32'h0000_0000;
        end else if (accept && !hwrite_in) begin
            hrdata_q <= rd_mux;
        end
    end

    assign hrdata_out = hrdata_q;
    assign hreadyout_out = 1'b1;
    assign hresp_out = 1'b0;

    // ---------------- scalers ----------------
    assign run = on_q && (period_q != pwtb_pkg::PERIOD_RST);

    assign pre_if.ev = run;
    assign pre_if.clr = wr_count || wr_ctrl;
    always_comb begin
        case (pre_sel_q)
            2'h0: pre_if.limit = pwtb_pkg::PRE_LIM_1;
            2'h1: pre_if.limit = pwtb_pkg::PRE_LIM_4;
            2'h2: pre_if.limit = pwtb_pkg::PRE_LIM_16;
            2'h3: pre_if.limit = pwtb_pkg::PRE_LIM_64;
            default: pre_if.limit = pwtb_pkg::PRE_LIM_1;
        endcase
    end
    assign tick = pre_if.hit;

    pwtb_scaler #(.W(pwtb_pkg::PRE_W)) u_prescale (
        .clock_in(clock_in),
        .resetn_in(resetn_in),
        .sc(pre_if.scl)
    );

    assign post_if.ev = post_ev;
    assign post_if.clr = wr_count || wr_ctrl;
    assign post_if.limit = post_sel_q;

    pwtb_scaler #(.W(pwtb_pkg::POST_W)) u_postscale (
        .clock_in(clock_in),
        .resetn_in(resetn_in),
        .sc(post_if.scl)
    );

    // ---------------- event decode ----------------
    assign match = (count_q == period_q);
    assign at_zero = (count_q == pwtb_pkg::COUNT_RST);
    assign going_down = (dir_q == pwtb_pkg::PWTB_DOWN);

    always_comb begin
        post_ev = 1'b0;
        direct_ev = 1'b0;
        case (mode_q)
            pwtb_pkg::PWTB_FREE: post_ev = tick && match;
            pwtb_pkg::PWTB_SINGLE: direct_ev = tick && match;
            pwtb_pkg::PWTB_UPDOWN: post_ev = tick && going_down && at_zero;
            pwtb_pkg::PWTB_DOUBLE: direct_ev = tick && ((going_down && at_zero) || (!going_down && match));
            default: post_ev = 1'b0;
        endcase
    end

    // tick is already gated by run, so a zero period yields no events
    assign tb_event = direct_ev || post_if.hit;
    assign sev_hit = tick && (count_q == sevt_q);

    // ---------------- counter ----------------
    always_ff @(posedge clock_in) begin
        if (!resetn_in) begin
            count_q <= pwtb_pkg::COUNT_RST;
        end else if (wr_count) begin
            count_q <= hwdata_in[CW-1:0];
        end else if (tick) begin
            case (mode_q)
                pwtb_pkg::PWTB_FREE, pwtb_pkg::PWTB_SINGLE: begin
                    count_q <= match ? pwtb_pkg::COUNT_RST : count_q + 15'h0001;
                end
                pwtb_pkg::PWTB_UPDOWN, pwtb_pkg::PWTB_DOUBLE: begin
                    if (!going_down) begin
                        count_q <= match ? count_q - 15'h0001 : count_q + 15'h0001;
                    end else begin
                        count_q <= at_zero ? count_q + 15'h0001 : count_q - 15'h0001;
                    end
                end
                default: count_q <= count_q;
            endcase
        end
    end

    always_ff @(posedge clock_in) begin
        if (!resetn_in) begin
            dir_q <= pwtb_pkg::PWTB_UP;
        end else if (tick) begin
            case (dir_q)
                pwtb_pkg::PWTB_UP: begin
                    if ((mode_q[1] == 1'b1) && match) begin
                        dir_q <= pwtb_pkg::PWTB_DOWN;
                    end
                end
                pwtb_pkg::PWTB_DOWN: begin
                    if ((mode_q[1] == 1'b0) || at_zero) begin
                        dir_q <= pwtb_pkg::PWTB_UP;
                    end
                end
                default: dir_q <= pwtb_pkg::PWTB_UP;
            endcase
        end
    end

    // ---------------- control registers ----------------
    always_ff @(posedge clock_in) begin
        if (!resetn_in) begin
            on_q <= 1'b0;
            mode_q <= pwtb_pkg::pwtb_mode_t'(pwtb_pkg::MODE_RST);
            pre_sel_q <= pwtb_pkg::PRE_RST;
            post_sel_q <= pwtb_pkg::POST_RST;
        end else if (wr_ctrl) begin
            on_q <= hwdata_in[pwtb_pkg::CTRL_ON_BIT];
            mode_q <= pwtb_pkg::pwtb_mode_t'(hwdata_in[pwtb_pkg::CTRL_MODE_LSB +: 2]);
            pre_sel_q <= hwdata_in[pwtb_pkg::CTRL_PRE_LSB +: 2];
            post_sel_q <= hwdata_in[pwtb_pkg::CTRL_POST_LSB +: 4];
        end else if (tick && match && (mode_q == pwtb_pkg::PWTB_SINGLE)) begin
            on_q <= 1'b0;
        end
    end

    // a zero period cannot be replaced while enabled; software must stop first
    always_ff @(posedge clock_in) begin
        if (!resetn_in) begin
            period_q <= pwtb_pkg::PERIOD_RST;
        end else if (wr_period && !(on_q && (period_q == pwtb_pkg::PERIOD_RST))) begin
            period_q <= hwdata_in[CW-1:0];
        end
    end

    always_ff @(posedge clock_in) begin
        if (!resetn_in) begin
            sevt_q <= pwtb_pkg::SEVT_RST;
        end else if (wr_sevt) begin
            sevt_q <= hwdata_in[CW-1:0];
        end
    end

    // ---------------- interrupts ----------------
    always_comb begin
        stat_set = '0;
        stat_set[pwtb_pkg::STAT_TB_BIT] = tb_event;
        stat_set[pwtb_pkg::STAT_SEV_BIT] = sev_hit;
    end

    // a new event in the clearing cycle survives the write-one-to-clear
    always_ff @(posedge clock_in) begin
        if (!resetn_in) begin
            status_q <= pwtb_pkg::STAT_RST;
        end else begin
            status_q <= (status_q & ~(wr_status ? hwdata_in[pwtb_pkg::STAT_W-1:0] : '0)) | stat_set;
        end
    end

    always_ff @(posedge clock_in) begin
        if (!resetn_in) begin
            mask_q <= pwtb_pkg::STAT_RST;
        end else if (wr_mask) begin
            mask_q <= hwdata_in[pwtb_pkg::STAT_W-1:0];
        end
    end

    always_ff @(posedge clock_in) begin
        if (!resetn_in) begin
            irq_q <= 1'b0;
            sev_q <= 1'b0;
        end else begin
            irq_q <= |(status_q & mask_q);
            sev_q <= sev_hit;
        end
    end

    assign count_value_out = count_q;
    // the down code is one-hot, so its high bit is the flag straight from the flop
    assign count_down_out = dir_q[1];
    assign special_event_out = sev_q;
    assign irq_out = irq_q;

    // ---------------- assertions ----------------
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!resetn_in);

    a_zero_period_stall: assert property (
        (period_q == 15'h0000) && !wr_count |=> $stable(count_q)
    ) else $error("count moved with a zero period");

    a_zero_period_quiet: assert property (
        (period_q == 15'h0000) |-> !tb_event && !sev_hit
    ) else $error("event raised with a zero period");

    a_disabled_holds: assert property (
        !on_q && !wr_count |=> $stable(count_q) && $stable(dir_q)
    ) else $error("counter moved while disabled");

    a_free_wrap: assert property (
        tick && match && (mode_q == pwtb_pkg::PWTB_FREE) && !wr_count
        |=> (count_q == 15'h0000) && status_q[0] == (status_q[0] | $past(post_if.hit))
    ) else $error("free-running counter did not wrap");

    a_single_stop: assert property (
        tick && match && (mode_q == pwtb_pkg::PWTB_SINGLE) && !wr_count && !wr_ctrl
        |=> !on_q && (count_q == 15'h0000) ##1 $stable(count_q)
    ) else $error("single-shot did not halt");

    a_single_event: assert property (
        tick && match && (mode_q == pwtb_pkg::PWTB_SINGLE) |-> tb_event
    ) else $error("single-shot final event missing");

    a_updown_turn: assert property (
        tick && match && !going_down && (mode_q == pwtb_pkg::PWTB_UPDOWN) && !wr_count && (period_q != 15'h0001)
        |=> going_down && (count_q == $past(period_q) - 15'h0001)
    ) else $error("up/down counter did not reverse at period");

    a_double_events: assert property (
        tick && (mode_q == pwtb_pkg::PWTB_DOUBLE) && (match || (going_down && at_zero)) && ((!going_down) == match)
        |-> tb_event
    ) else $error("double-update event missing");

    a_event_sticky: assert property (
        tb_event |=> status_q[pwtb_pkg::STAT_TB_BIT] ##1 (irq_out == |$past(status_q & mask_q))
    ) else $error("event not latched into status");

    a_dir_readback: assert property (
        accept && !hwrite_in && (haddr_in[7:0] == pwtb_pkg::OFS_COUNT)
        |=> hrdata_out[15] == $past(going_down) && hrdata_out[14:0] == $past(count_q)
    ) else $error("count readback wrong");

    a_ctrl_clears_scale: assert property (
        wr_ctrl && run |-> !tick
    ) else $error("prescaler ticked during control write");

    c_free_wrap: cover property (tick && match && (mode_q == pwtb_pkg::PWTB_FREE));
    c_single_done: cover property (tick && match && (mode_q == pwtb_pkg::PWTB_SINGLE));
    c_updown_zero: cover property (tick && going_down && at_zero && (mode_q == pwtb_pkg::PWTB_UPDOWN));
    c_irq_raised: cover property ($rose(irq_out));
endmodule : pwtb_time_base
`default_nettype wire

// *** pwtb_time_base_test.sv ***
// self-checking bench for the pwm time base, driven over its ahb-lite port
`timescale 1ns/10ps
`default_nettype none
module pwtb_time_base_test;
    logic clock_in = 1'b0;
    logic resetn_in = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h00000000;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h00000000;
    logic [31:0] hrdata_out;
    logic hreadyout_out;
    logic hresp_out;
    logic [14:0] count_value_out;
    logic count_down_out;
    logic special_event_out;
    logic irq_out;
    int err_total = 0;
    int checks_done = 0;
    int k;
    int n;
    logic [1:0] t_mode [4] = '{2'h0, 2'h0, 2'h2, 2'h3};
    logic [3:0] t_post [4] = '{4'h0, 4'h3, 4'h1, 4'h3};
    int t_gap [4] = '{8, 32, 28, 7};
    int t_pre [4] = '{1, 4, 16, 64};

    always #50 clock_in = ~clock_in;

    // hready of the bus is the only slave's hreadyout
    pwtb_time_base dut (
        .clock_in(clock_in),
        .resetn_in(resetn_in),
        .hsel_in(hsel),
        .haddr_in(haddr),
        .htrans_in(htrans),
        .hwrite_in(hwrite),
        .hsize_in(hsize),
        .hwdata_in(hwdata),
        .hready_in(hreadyout_out),
        .hrdata_out(hrdata_out),
        .hreadyout_out(hreadyout_out),
        .hresp_out(hresp_out),
        .count_value_out(count_value_out),
        .count_down_out(count_down_out),
        .special_event_out(special_event_out),
        .irq_out(irq_out)
    );

    task automatic summarize();
        if (err_total == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : summarize

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk_word

    task automatic chk_bit(input logic got, input logic exp, input string what);
        chk_word({31'h0, got}, {31'h0, exp}, what);
    endtask : chk_bit

    // called right after a rising edge; the answer is awaited, not assumed
    task automatic ahb_cycle(input logic [7:0] a, input logic wr, input logic [31:0] d, output logic [31:0] r);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        htrans <= 2'b10;
        hwrite <= wr;
        do @(posedge clock_in); while (hreadyout_out !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clock_in); while (hreadyout_out !== 1'b1);
        r = hrdata_out;
    endtask : ahb_cycle

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        ahb_cycle(a, 1'b1, d, r);
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
        logic [31:0] r;
        ahb_cycle(a, 1'b0, 32'h00000000, r);
        chk_word(r, exp, what);
        chk_bit(hresp_out, 1'b0, "bus response");
    endtask : rd_chk

    function automatic logic [31:0] ctl(input logic on, input logic [3:0] post, input logic [1:0] pre,
                                        input logic [1:0] md);
        ctl = 32'h00000000;
        ctl[pwtb_pkg::CTRL_ON_BIT] = on;
        ctl[pwtb_pkg::CTRL_POST_LSB +: 4] = post;
        ctl[pwtb_pkg::CTRL_PRE_LSB +: 2] = pre;
        ctl[pwtb_pkg::CTRL_MODE_LSB +: 2] = md;
    endfunction : ctl

    // follows the counter tick by tick at 1:1 prescale and compares it with a model
    task automatic track(input logic [1:0] md, input int per, input int cyc);
        logic [14:0] c;
        logic d;
        logic h;
        c = count_value_out;
        d = count_down_out;
        h = 1'b0;
        for (int i = 0; i < cyc; i++) begin
            @(posedge clock_in);
            if (h) begin
                c = c;
            end else if (md[1] && !d && c == per) begin
                c = c - 15'h1;
                d = 1'b1;
            end else if (md[1] && d && c == 0) begin
                c = 15'h1;
                d = 1'b0;
            end else if (md[1]) begin
                c = d ? c - 15'h1 : c + 15'h1;
            end else if (c == per) begin
                c = 15'h0;
                h = md[0];
            end else begin
                c = c + 15'h1;
            end
            chk_word({17'h0, count_value_out}, {17'h0, c}, "count trajectory");
            chk_bit(count_down_out, d, "count direction");
        end
    endtask : track

    // clears the event, then counts edges until irq rises again
    task automatic irq_gap(output int g);
        wr(pwtb_pkg::OFS_STATUS, 32'h00000001);
        g = 2;
        while (irq_out !== 1'b0 && g < 200) begin
            @(posedge clock_in);
            g++;
        end
        while (irq_out !== 1'b1 && g < 200) begin
            @(posedge clock_in);
            g++;
        end
    endtask : irq_gap

    task automatic tick_gap(output int g);
        logic [14:0] v;
        for (int j = 0; j < 2; j++) begin
            v = count_value_out;
            g = 0;
            while (count_value_out === v && g < 200) begin
                @(posedge clock_in);
                g++;
            end
        end
    endtask : tick_gap

    initial begin
        repeat (20000) @(posedge clock_in);
        err_total++;
        summarize();
    end

    initial begin
        repeat (8) @(posedge clock_in);
        resetn_in <= 1'b1;
        @(posedge clock_in);
        @(posedge clock_in);
        rd_chk(pwtb_pkg::OFS_CTRL, 32'h00000000, "control after reset");
        rd_chk(pwtb_pkg::OFS_COUNT, 32'h00000000, "count after reset");
        rd_chk(pwtb_pkg::OFS_PERIOD, 32'h00000000, "period after reset");
        rd_chk(pwtb_pkg::OFS_STATUS, 32'h00000000, "status after reset");
        rd_chk(pwtb_pkg::OFS_MASK, 32'h00000000, "mask after reset");
        wr(8'h18, 32'hffffffff);
        rd_chk(8'h18, 32'h00000000, "unmapped word");
        wr(pwtb_pkg::OFS_COUNT, 32'h0000ffff);
        rd_chk(pwtb_pkg::OFS_COUNT, 32'h00007fff, "count write, direction read-only");
        // zero period: no counting, no events, period write refused while on
        wr(pwtb_pkg::OFS_COUNT, 32'h00000000);
        wr(pwtb_pkg::OFS_MASK, 32'h00000003);
        wr(pwtb_pkg::OFS_CTRL, ctl(1'b1, 4'h0, 2'h0, 2'h0));
        repeat (20) @(posedge clock_in);
        chk_word({17'h0, count_value_out}, 32'h00000000, "count at zero period");
        chk_bit(irq_out, 1'b0, "irq at zero period");
        rd_chk(pwtb_pkg::OFS_STATUS, 32'h00000000, "no events at zero period");
        wr(pwtb_pkg::OFS_PERIOD, 32'h00000005);
        rd_chk(pwtb_pkg::OFS_PERIOD, 32'h00000000, "zero period held while on");
        // compare parked out of reach, so special events cannot keep irq high below
        wr(pwtb_pkg::OFS_SEVT, 32'h00007fff);
        // free, up/down and double-update modes, with postscaling where it applies
        for (k = 0; k < 4; k++) begin
            wr(pwtb_pkg::OFS_CTRL, 32'h00000000);
            wr(pwtb_pkg::OFS_COUNT, 32'h00000000);
            wr(pwtb_pkg::OFS_PERIOD, 32'h00000007);
            wr(pwtb_pkg::OFS_CTRL, ctl(1'b1, t_post[k], 2'h0, t_mode[k]));
            repeat (3) @(posedge clock_in);
            track(t_mode[k], 7, 20);
            irq_gap(n);
            irq_gap(n);
            chk_word(n, t_gap[k], "event spacing");
        end
        // masked event still lands in status but keeps irq low
        wr(pwtb_pkg::OFS_MASK, 32'h00000000);
        wr(pwtb_pkg::OFS_STATUS, 32'h00000003);
        repeat (20) @(posedge clock_in);
        chk_bit(irq_out, 1'b0, "masked irq");
        rd_chk(pwtb_pkg::OFS_STATUS, 32'h00000001, "sticky status under mask");
        wr(pwtb_pkg::OFS_MASK, 32'h00000001);
        repeat (3) @(posedge clock_in);
        chk_bit(irq_out, 1'b1, "unmasked irq");
        // single shot halts itself, one event despite postscale 1:4
        wr(pwtb_pkg::OFS_CTRL, 32'h00000000);
        wr(pwtb_pkg::OFS_COUNT, 32'h00000000);
        wr(pwtb_pkg::OFS_PERIOD, 32'h00000005);
        wr(pwtb_pkg::OFS_STATUS, 32'h00000003);
        wr(pwtb_pkg::OFS_CTRL, ctl(1'b1, 4'h3, 2'h0, 2'h1));
        repeat (3) @(posedge clock_in);
        track(2'h1, 5, 12);
        rd_chk(pwtb_pkg::OFS_CTRL, ctl(1'b0, 4'h3, 2'h0, 2'h1), "enable cleared by hardware");
        rd_chk(pwtb_pkg::OFS_STATUS, 32'h00000001, "single shot event");
        // prescaler ratios, each control write restarts the prescale count
        wr(pwtb_pkg::OFS_PERIOD, 32'h00007fff);
        for (k = 0; k < 4; k++) begin
            wr(pwtb_pkg::OFS_CTRL, ctl(1'b1, 4'h0, k[1:0], 2'h0));
            tick_gap(n);
            chk_word(n, t_pre[k], "prescale ratio");
        end
        // freeze while counting down: direction and count survive disable
        wr(pwtb_pkg::OFS_CTRL, 32'h00000000);
        wr(pwtb_pkg::OFS_PERIOD, 32'h00000002);
        wr(pwtb_pkg::OFS_COUNT, 32'h00000002);
        wr(pwtb_pkg::OFS_CTRL, ctl(1'b1, 4'h0, 2'h3, 2'h2));
        repeat (90) @(posedge clock_in);
        wr(pwtb_pkg::OFS_CTRL, ctl(1'b0, 4'h0, 2'h3, 2'h2));
        repeat (80) @(posedge clock_in);
        rd_chk(pwtb_pkg::OFS_COUNT, 32'h00008001, "frozen down count");
        // special event: one-cycle pulse the cycle after the count equals the compare value
        wr(pwtb_pkg::OFS_SEVT, 32'h00000003);
        wr(pwtb_pkg::OFS_PERIOD, 32'h00000007);
        wr(pwtb_pkg::OFS_STATUS, 32'h00000003);
        wr(pwtb_pkg::OFS_CTRL, ctl(1'b1, 4'h0, 2'h0, 2'h0));
        n = 0;
        while (special_event_out !== 1'b1 && n < 200) begin
            @(posedge clock_in);
            n++;
        end
        chk_word({17'h0, count_value_out}, 32'h00000004, "count after special event");
        @(posedge clock_in);
        chk_bit(special_event_out, 1'b0, "special event single cycle");
        rd_chk(pwtb_pkg::OFS_STATUS, 32'h00000002, "special event status");
        summarize();
    end
endmodule : pwtb_time_base_test
`default_nettype wire
